/* File: crs_pkg.sv */
// Constants and carrier types for the core regulator sequencer.
// Assumes a 125 MHz core clock and an Avalon-MM master on the register bus.
`default_nettype none
package crs_pkg;
  localparam int CLK_MHZ = 125;
  localparam int RESET_US = 55;
  localparam int BOOT_HOLD_US = 100;
  localparam int PG_DELAY_MS = 9;
  localparam int LIMIT_MS = 9;
  localparam int SKEW_NS = 400;
  localparam int MASK_US = 130;
  localparam int POST_MASK_US = 100;
  localparam int SLOW_NS_PER_STEP = 2000;
  localparam int FAST_NS_PER_STEP = 500;
  localparam int RESET_CYC = RESET_US * CLK_MHZ;
  localparam int BOOT_HOLD_CYC = BOOT_HOLD_US * CLK_MHZ;
  localparam int PG_DELAY_CYC = PG_DELAY_MS * 1000 * CLK_MHZ;
  localparam int LIMIT_CYC = LIMIT_MS * 1000 * CLK_MHZ;
  localparam int SKEW_CYC = (SKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int MASK_CYC = MASK_US * CLK_MHZ;
  localparam int POST_MASK_CYC = POST_MASK_US * CLK_MHZ;
  localparam int SLOW_STEP_CYC = SLOW_NS_PER_STEP * CLK_MHZ / 1000;
  localparam int FAST_STEP_CYC = FAST_NS_PER_STEP * CLK_MHZ / 1000;
  localparam int CNT_W = 32;
  localparam logic [6:0] CODE_ZERO = 7'h00;
  localparam logic [6:0] CODE_LOW_LIMIT = 7'h18;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CODE = 4'h2;
  localparam logic [3:0] ADDR_BOOT = 4'h3;
  localparam logic [6:0] BOOT_CODE_RST = 7'h30;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hdeadbeef;
  typedef enum logic [2:0] {
    CRS_OFF,
    CRS_RESET,
    CRS_SOFT,
    CRS_BOOT,
    CRS_PGWAIT,
    CRS_RUN,
    CRS_LATCH
  } crs_state_t;
  typedef struct packed {
    logic ov_high;
    logic uv_low;
    logic below_200;
    logic drop_200;
    logic over_limit;
  } crs_sense_t;
endpackage
`default_nettype wire

/* File: crs_seq.sv */
// Sequencer, code tracking, power-good masking and current-limit latch-off.
// Analog comparators arrive as pin levels; registers are on Avalon-MM.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`default_nettype none
// How it works
// - Supply good and enable high start a 55 us reset interval first.
// - After reset, sample phase count, then issue go to begin soft start.
// - Soft start steps the target code from zero to the boot code.
// - Hold boot level 100 us, then drive clock enable low.
// - Power good rises 9 ms after clock enable went low.
// - Voltage code inputs ignored until clock enable is low.
// - Discharge switch on during lockout or shutdown.
// - Enable low or lockout resets soft start and delay state.
// - New code ignored at least 400 ns after any change.
// - Every code change restarts the power-good mask timer.
// - Internal code steps through every intermediate code to target.
// - Mask holds 100 us after the last internal step.
// - Down steps with sleep request high are paced at 3.125 mV/us.
// - Up steps are 12.5 mV/us with sleep low, 3.125 with it high.
// - Power good needs output inside window; low window waived near zero.
// - Mask about 130 us after code change or sleep entry/exit.
// - Drop over 200 mV while sleep request is high extends an active mask.
// - Enter current limit when limit current exceeds reference.
// - Current limit lasting 9 ms latches the device off.
// - Latch clears only by supply cycle, enable pulsed low or the CTRL software enable written low.
// - Below 200 mV at start-up, clamp ramp termination at 1.5 V.
// - Two-phase mode alternates ramp cycles between phases.
// - Force fixed-frequency mode during any code transient.
module crs_seq
  import crs_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic enable_pin,
  input wire logic supply_low_lockout,
  input wire logic two_phase_pin,
  input wire logic [6:0] voltage_code_inputs,
  input wire logic deep_sleep_request,
  input wire logic [4:0] sense_pins,
  input wire logic ramp_cycle,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic cpu_clock_go_n,
  output logic power_good_out,
  output logic output_sense_ref_discharge,
  output logic [6:0] target_code,
  output logic force_pwm,
  output logic secondary_clamp,
  output logic phase1_req,
  output logic phase2_req,
  output logic two_phase_active
);
  // Three-stage pin synchronisers, accepted when stages two and three agree
  logic [2:0] en_s_q, uv_s_q, dsl_s_q, tp_s_q, rc_s_q;
  logic [2:0][6:0] code_s_q;
  logic [2:0][4:0] sns_s_q;
  logic en_f_q, uv_f_q, dsl_f_q, tp_f_q, rc_f_q;
  logic [6:0] code_f_q;
  crs_sense_t sns_f_q;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en_s_q <= '0;
      uv_s_q <= 3'h7;
      dsl_s_q <= '0;
      tp_s_q <= '0;
      rc_s_q <= '0;
      code_s_q <= '0;
      sns_s_q <= '0;
      en_f_q <= 1'b0;
      uv_f_q <= 1'b1;
      dsl_f_q <= 1'b0;
      tp_f_q <= 1'b0;
      rc_f_q <= 1'b0;
      code_f_q <= CODE_ZERO;
      sns_f_q <= '0;
    end
    else
    begin
      en_s_q <= {en_s_q[1:0], enable_pin};
      uv_s_q <= {uv_s_q[1:0], supply_low_lockout};
      dsl_s_q <= {dsl_s_q[1:0], deep_sleep_request};
      tp_s_q <= {tp_s_q[1:0], two_phase_pin};
      rc_s_q <= {rc_s_q[1:0], ramp_cycle};
      code_s_q <= {code_s_q[1:0], voltage_code_inputs};
      sns_s_q <= {sns_s_q[1:0], sense_pins};
      if (en_s_q[2] == en_s_q[1]) en_f_q <= en_s_q[2];
      if (uv_s_q[2] == uv_s_q[1]) uv_f_q <= uv_s_q[2];
      if (dsl_s_q[2] == dsl_s_q[1]) dsl_f_q <= dsl_s_q[2];
      if (tp_s_q[2] == tp_s_q[1]) tp_f_q <= tp_s_q[2];
      if (rc_s_q[2] == rc_s_q[1]) rc_f_q <= rc_s_q[2];
      if (code_s_q[2] == code_s_q[1]) code_f_q <= code_s_q[2];
      if (sns_s_q[2] == sns_s_q[1]) sns_f_q <= sns_s_q[2];
    end
  end

  // Software registers
  logic [6:0] boot_code_q, boot_code_d;
  logic sw_enable_q, sw_enable_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;

  // Sequencer state
  crs_state_t state_q, state_d;
  logic [CNT_W-1:0] seq_cnt_q, seq_cnt_d;
  logic [CNT_W-1:0] lim_cnt_q, lim_cnt_d;
  logic [CNT_W-1:0] skew_cnt_q, skew_cnt_d;
  logic [CNT_W-1:0] mask_cnt_q, mask_cnt_d;
  logic [CNT_W-1:0] step_cnt_q, step_cnt_d;
  logic [6:0] cur_code_q, cur_code_d;
  logic [6:0] seen_code_q, seen_code_d;
  logic [6:0] goal_code_q, goal_code_d;
  logic dsl_prev_q, dsl_prev_d;
  logic phases_q, phases_d;
  logic clk_go_n_q, clk_go_n_d;
  logic pg_q, pg_d;
  logic phase_sel_q, phase_sel_d;
  logic rc_prev_q, rc_prev_d;
  logic go_on;
  logic stepping;
  logic tracking;
  logic [CNT_W-1:0] step_len;

  assign go_on = en_f_q && !uv_f_q && sw_enable_q;
  assign tracking = (state_q == CRS_PGWAIT) || (state_q == CRS_RUN);
  assign stepping = cur_code_q != goal_code_q;
  // Slow pace on descent, or ascent with sleep still high
  always_comb
  begin
    if (cur_code_q > goal_code_q || dsl_f_q) step_len = CNT_W'(SLOW_STEP_CYC);
    else step_len = CNT_W'(FAST_STEP_CYC);
  end

  always_comb
  begin
    state_d = state_q;
    seq_cnt_d = seq_cnt_q;
    lim_cnt_d = lim_cnt_q;
    skew_cnt_d = skew_cnt_q;
    mask_cnt_d = mask_cnt_q;
    step_cnt_d = step_cnt_q;
    cur_code_d = cur_code_q;
    seen_code_d = seen_code_q;
    goal_code_d = goal_code_q;
    dsl_prev_d = dsl_f_q;
    phases_d = phases_q;
    clk_go_n_d = clk_go_n_q;
    pg_d = pg_q;
    rc_prev_d = rc_f_q;
    phase_sel_d = phase_sel_q;
    if (rc_f_q && !rc_prev_q) phase_sel_d = !phase_sel_q;
    if (!go_on)
    begin
      // Lockout or enable low also clears the latch
      state_d = CRS_OFF;
      seq_cnt_d = '0;
      lim_cnt_d = '0;
      cur_code_d = CODE_ZERO;
      goal_code_d = CODE_ZERO;
      clk_go_n_d = 1'b1;
      pg_d = 1'b0;
      mask_cnt_d = '0;
      skew_cnt_d = '0;
    end
    else
    begin
      seq_cnt_d = seq_cnt_q + CNT_W'(1);
      unique case (state_q)
        CRS_OFF:
        begin
          state_d = CRS_RESET;
          seq_cnt_d = '0;
        end
        CRS_RESET:
          if (seq_cnt_q >= CNT_W'(RESET_CYC - 1))
          begin
            phases_d = tp_f_q;
            state_d = CRS_SOFT;
            seq_cnt_d = '0;
            goal_code_d = boot_code_q;
            step_cnt_d = '0;
          end
        CRS_SOFT:
          if (!stepping)
          begin
            state_d = CRS_BOOT;
            seq_cnt_d = '0;
          end
        CRS_BOOT:
          if (seq_cnt_q >= CNT_W'(BOOT_HOLD_CYC - 1))
          begin
            clk_go_n_d = 1'b0;
            state_d = CRS_PGWAIT;
            seq_cnt_d = '0;
            seen_code_d = code_f_q;
            skew_cnt_d = CNT_W'(SKEW_CYC);
          end
        CRS_PGWAIT:
          if (seq_cnt_q >= CNT_W'(PG_DELAY_CYC - 1))
          begin
            state_d = CRS_RUN;
            mask_cnt_d = '0;
          end
        CRS_RUN:
        begin
        end
        CRS_LATCH:
          pg_d = 1'b0;
      endcase
      // Internal code walks one code at a time
      if (state_q != CRS_LATCH && stepping)
      begin
        if (step_cnt_q >= step_len - CNT_W'(1))
        begin
          step_cnt_d = '0;
          cur_code_d = (cur_code_q < goal_code_q) ? cur_code_q + 7'h01 : cur_code_q - 7'h01;
          if (tracking) mask_cnt_d = CNT_W'(POST_MASK_CYC);
        end
        else
          step_cnt_d = step_cnt_q + CNT_W'(1);
      end
      // Code inputs take effect only once clock enable is low
      if (tracking)
      begin
        if (code_f_q != seen_code_q)
        begin
          seen_code_d = code_f_q;
          skew_cnt_d = CNT_W'(SKEW_CYC);
          mask_cnt_d = CNT_W'(MASK_CYC);
        end
        else if (skew_cnt_q != '0)
        begin
          skew_cnt_d = skew_cnt_q - CNT_W'(1);
          if (skew_cnt_q == CNT_W'(1)) goal_code_d = seen_code_q;
        end
        if (dsl_f_q != dsl_prev_q) mask_cnt_d = CNT_W'(MASK_CYC);
        // Deep drop while sleep request is high keeps the mask alive
        if (sns_f_q.drop_200 && dsl_f_q && mask_cnt_q != '0 && mask_cnt_q < CNT_W'(MASK_CYC))
          mask_cnt_d = CNT_W'(MASK_CYC);
        else if (mask_cnt_q != '0 && code_f_q == seen_code_q && dsl_f_q == dsl_prev_q
          && !(stepping && step_cnt_q >= step_len - CNT_W'(1)))
          mask_cnt_d = mask_cnt_q - CNT_W'(1);
      end
      if (state_q != CRS_LATCH)
      begin
        if (sns_f_q.over_limit)
        begin
          lim_cnt_d = lim_cnt_q + CNT_W'(1);
          if (lim_cnt_q >= CNT_W'(LIMIT_CYC - 1))
          begin
            state_d = CRS_LATCH;
            pg_d = 1'b0;
          end
        end
        else
          lim_cnt_d = '0;
      end
      if (state_q == CRS_RUN)
      begin
        if (mask_cnt_q == '0 && !stepping && skew_cnt_q == '0)
          pg_d = !sns_f_q.ov_high && (!sns_f_q.uv_low || cur_code_q < CODE_LOW_LIMIT);
        else if (mask_cnt_q == '0 && sns_f_q.ov_high)
          pg_d = 1'b0;
      end
      if (state_q == CRS_PGWAIT && seq_cnt_q >= CNT_W'(PG_DELAY_CYC - 1))
        pg_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= CRS_OFF;
      seq_cnt_q <= '0;
      lim_cnt_q <= '0;
      skew_cnt_q <= '0;
      mask_cnt_q <= '0;
      step_cnt_q <= '0;
      cur_code_q <= CODE_ZERO;
      seen_code_q <= CODE_ZERO;
      goal_code_q <= CODE_ZERO;
      dsl_prev_q <= 1'b0;
      phases_q <= 1'b0;
      clk_go_n_q <= 1'b1;
      pg_q <= 1'b0;
      phase_sel_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      seq_cnt_q <= seq_cnt_d;
      lim_cnt_q <= lim_cnt_d;
      skew_cnt_q <= skew_cnt_d;
      mask_cnt_q <= mask_cnt_d;
      step_cnt_q <= step_cnt_d;
      cur_code_q <= cur_code_d;
      seen_code_q <= seen_code_d;
      goal_code_q <= goal_code_d;
      dsl_prev_q <= dsl_prev_d;
      phases_q <= phases_d;
      clk_go_n_q <= clk_go_n_d;
      pg_q <= pg_d;
      phase_sel_q <= phase_sel_d;
      rc_prev_q <= rc_prev_d;
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  always_comb
  begin
    boot_code_d = boot_code_q;
    sw_enable_d = sw_enable_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    if ((avs_read || avs_write) && !ack_q)
    begin
      ack_d = 1'b1;
      unique case (avs_address)
        ADDR_CTRL: rdata_d = {31'h0, sw_enable_q};
        ADDR_STATUS: rdata_d = {25'h0, state_q, phases_q, pg_q, clk_go_n_q, mask_cnt_q != '0};
        ADDR_CODE: rdata_d = {17'h0, goal_code_q, 1'b0, cur_code_q};
        ADDR_BOOT: rdata_d = {25'h0, boot_code_q};
        default: rdata_d = BAD_ADDR_DATA;
      endcase
    end
    // Write lands on the edge where waitrequest is seen low
    if (avs_write && ack_q)
    begin
      if (avs_address == ADDR_CTRL) sw_enable_d = avs_writedata[0];
      if (avs_address == ADDR_BOOT) boot_code_d = avs_writedata[6:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_code_q <= BOOT_CODE_RST;
      sw_enable_q <= 1'b1;
      ack_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      boot_code_q <= boot_code_d;
      sw_enable_q <= sw_enable_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign cpu_clock_go_n = clk_go_n_q;
  assign power_good_out = pg_q && state_q != CRS_LATCH;
  assign output_sense_ref_discharge = !(en_f_q && !uv_f_q);
  assign target_code = cur_code_q;
  assign force_pwm = stepping || mask_cnt_q != '0 || skew_cnt_q != '0;
  assign secondary_clamp = (state_q == CRS_SOFT || state_q == CRS_BOOT) && sns_f_q.below_200;
  assign two_phase_active = phases_q;
  assign phase1_req = go_on && state_q != CRS_LATCH && state_q != CRS_RESET && state_q != CRS_OFF
    && (!phases_q || !phase_sel_q);
  assign phase2_req = go_on && state_q != CRS_LATCH && state_q != CRS_RESET && state_q != CRS_OFF
    && phases_q && phase_sel_q;
endmodule
`default_nettype wire

/* File: crs_seq_checker.sv */
// Concurrent checks on the ports of crs_seq, attached by bind.
// Assumes crs_pkg is compiled first and one core clock domain.
`default_nettype none
module crs_seq_checker
  import crs_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic supply_low_lockout,
  input wire logic cpu_clock_go_n,
  input wire logic power_good_out,
  input wire logic output_sense_ref_discharge,
  input wire logic [6:0] target_code,
  input wire logic force_pwm,
  input wire logic phase1_req,
  input wire logic phase2_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic [6:0] code_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Cycles since the internal code last moved
  always_comb
  begin
    gap_d = (target_code != code_q) ? 16'h0000 : ((gap_q == 16'hffff) ? gap_q : gap_q + 16'h0001);
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gap_q <= 16'h0000;
      code_q <= 7'h00;
    end
    else
    begin
      gap_q <= gap_d;
      code_q <= target_code;
    end
  end
  property p_dis;
    supply_low_lockout [*6] |-> output_sense_ref_discharge;
  endproperty
  a_dis: assert property (p_dis) else $error("discharge off in lockout");
  property p_shut;
    supply_low_lockout [*8] |-> cpu_clock_go_n && !power_good_out;
  endproperty
  a_shut: assert property (p_shut) else $error("sequence not reset in lockout");
  property p_pg;
    power_good_out |-> !cpu_clock_go_n;
  endproperty
  a_pg: assert property (p_pg) else $error("power good before clock enable");
  property p_boot;
    $fell(cpu_clock_go_n) |-> gap_q >= BOOT_HOLD_CYC - 2;
  endproperty
  a_boot: assert property (p_boot) else $error("boot level not held");
  property p_step;
    disable iff (!nrst || output_sense_ref_discharge)
    $changed(target_code) |-> 7'(target_code - $past(target_code)) inside {7'h01, 7'h7f};
  endproperty
  a_step: assert property (p_step) else $error("code jumped");
  property p_fast;
    disable iff (!nrst || output_sense_ref_discharge)
    $changed(target_code) |-> gap_q >= FAST_STEP_CYC - 2;
  endproperty
  a_fast: assert property (p_fast) else $error("code step too soon");
  property p_slow;
    disable iff (!nrst || output_sense_ref_discharge)
    $changed(target_code) && target_code < $past(target_code) |-> gap_q >= SLOW_STEP_CYC - 2;
  endproperty
  a_slow: assert property (p_slow) else $error("down step too soon");
  property p_pwm;
    disable iff (!nrst || output_sense_ref_discharge)
    $changed(target_code) && !cpu_clock_go_n |-> ##[0:1] force_pwm;
  endproperty
  a_pwm: assert property (p_pwm) else $error("no fixed frequency in transient");
  property p_excl;
    !(phase1_req && phase2_req);
  endproperty
  a_excl: assert property (p_excl) else $error("both phases requested");
  c_go: cover property ($fell(cpu_clock_go_n));
  c_down: cover property ($changed(target_code) && target_code < $past(target_code));
  c_lock: cover property (supply_low_lockout [*8]);
endmodule
bind crs_seq crs_seq_checker u_crs_chk (
  .core_clk(core_clk),
  .nrst(nrst),
  .supply_low_lockout(supply_low_lockout),
  .cpu_clock_go_n(cpu_clock_go_n),
  .power_good_out(power_good_out),
  .output_sense_ref_discharge(output_sense_ref_discharge),
  .target_code(target_code),
  .force_pwm(force_pwm),
  .phase1_req(phase1_req),
  .phase2_req(phase2_req)
);
`default_nettype wire

/* File: crs_host.sv */
// Host processor model: walks the code inputs one step at a time to goal.
// Assumes goal and sleep_in change just after core_clk rising edges.
`default_nettype none
module crs_host #(parameter int STEP = 100)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [6:0] goal,
  input wire logic sleep_in,
  output logic [6:0] voltage_code_inputs,
  output logic deep_sleep_request
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 0;
      voltage_code_inputs <= 7'h00;
      deep_sleep_request <= 1'b0;
    end
    else
    begin
      deep_sleep_request <= sleep_in;
      cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
      if (cnt == STEP - 1 && goal > voltage_code_inputs)
        voltage_code_inputs <= voltage_code_inputs + 7'h01;
      else if (cnt == STEP - 1 && goal < voltage_code_inputs)
        voltage_code_inputs <= voltage_code_inputs - 7'h01;
    end
  end
endmodule
`default_nettype wire

/* File: crs_seq_tb.sv */
// Self-checking bench for crs_seq with the host model on the code inputs.
// Assumes crs_pkg, crs_seq, crs_host and the checker are compiled first.
`default_nettype none
module crs_seq_tb
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, nrst = 1'b0, enable_pin = 1'b1, supply_low_lockout = 1'b0;
  logic two_phase_pin = 1'b1, sleep_in = 1'b0, ramp_cycle = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [6:0] goal = 7'h00;
  logic [4:0] sense_pins = 5'h00;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, q, avs_readdata;
  logic [15:0] rnd = 16'h58fb;
  logic [6:0] voltage_code_inputs, target_code;
  logic deep_sleep_request, avs_waitrequest, cpu_clock_go_n, power_good_out, output_sense_ref_discharge;
  logic force_pwm, secondary_clamp, phase1_req, phase2_req, two_phase_active;
  int err_total = 0, n_tests = 0, n;
  crs_seq dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .enable_pin(enable_pin),
    .supply_low_lockout(supply_low_lockout),
    .two_phase_pin(two_phase_pin),
    .voltage_code_inputs(voltage_code_inputs),
    .deep_sleep_request(deep_sleep_request),
    .sense_pins(sense_pins),
    .ramp_cycle(ramp_cycle),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cpu_clock_go_n(cpu_clock_go_n),
    .power_good_out(power_good_out),
    .output_sense_ref_discharge(output_sense_ref_discharge),
    .target_code(target_code),
    .force_pwm(force_pwm),
    .secondary_clamp(secondary_clamp),
    .phase1_req(phase1_req),
    .phase2_req(phase2_req),
    .two_phase_active(two_phase_active)
  );
  crs_host host (
    .core_clk(core_clk),
    .nrst(nrst),
    .goal(goal),
    .sleep_in(sleep_in),
    .voltage_code_inputs(voltage_code_inputs),
    .deep_sleep_request(deep_sleep_request)
  );
  always #4 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Random comparator levels and ramp edges; current limit kept quiet
  always @(posedge core_clk)
  begin
    rnd <= lfsr(rnd);
    sense_pins <= {rnd[4:1], 1'b0};
    ramp_cycle <= rnd[5];
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Held until waitrequest is low; only the watchdog ends a stuck wait
    do
      @(negedge core_clk);
    while (avs_waitrequest !== 1'b0);
    @(posedge core_clk);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_code(input logic [6:0] c, input logic on_host, output int m);
    for (m = 0; m < 30000; m++)
    begin
      @(negedge core_clk);
      if ((on_host ? voltage_code_inputs : target_code) === c) break;
    end
  endtask
  task automatic wait_go(output int m);
    for (m = 0; m < 30000; m++)
    begin
      @(negedge core_clk);
      if (cpu_clock_go_n === 1'b0) break;
    end
  endtask
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #(90000 * 8);
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    bus(1'b0, ADDR_BOOT, 32'h0, q);
    chk(q & 32'h7f, 32'(BOOT_CODE_RST));
    bus(1'b1, ADDR_BOOT, 32'h28, q);
    bus(1'b0, ADDR_BOOT, 32'h0, q);
    chk(q & 32'h7f, 32'h28);
    bus(1'b0, 4'hf, 32'h0, q);
    chk(q, BAD_ADDR_DATA);
    goal <= 7'h50;
    repeat (RESET_CYC - 200) @(negedge core_clk);
    chk(32'(target_code), 32'h0);
    wait_go(n);
    chk(32'(n >= 150 + BOOT_HOLD_CYC + 39 * FAST_STEP_CYC), 32'h1);
    chk(32'(target_code), 32'h28);
    chk(32'(two_phase_active), 32'h1);
    chk(32'(secondary_clamp), 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk(q & 32'he, 32'h8);
    $display("start-up test done");
    wait_code(7'h50, 1'b0, n);
    chk(32'(target_code), 32'h50);
    chk(32'(force_pwm), 32'h1);
    @(posedge core_clk);
    goal <= 7'h51;
    wait_code(7'h51, 1'b1, n);
    repeat (30) @(negedge core_clk);
    bus(1'b0, ADDR_CODE, 32'h0, q);
    chk((q >> 8) & 32'h7f, 32'h50);
    chk(32'(target_code), 32'h50);
    wait_code(7'h51, 1'b0, n);
    chk(32'(target_code), 32'h51);
    $display("code tracking test done");
    // Sleep entry, slow exit, down with sleep low, fast exit
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      sleep_in <= (i < 2);
      goal <= i[0] ? 7'h51 : 7'h41;
      wait_code(i[0] ? 7'h51 : 7'h41, 1'b0, n);
      chk(32'(target_code), 32'(i[0] ? 7'h51 : 7'h41));
      chk(32'(n >= 15 * SLOW_STEP_CYC), 32'(i != 3));
    end
    $display("slew test done");
    @(posedge core_clk);
    enable_pin <= 1'b0;
    two_phase_pin <= 1'b0;
    repeat (10) @(negedge core_clk);
    chk(32'(output_sense_ref_discharge), 32'h1);
    chk(32'({cpu_clock_go_n, power_good_out}), 32'h2);
    chk(32'(secondary_clamp), 32'h0);
    @(posedge core_clk);
    enable_pin <= 1'b1;
    wait_go(n);
    chk(32'(n >= RESET_CYC + BOOT_HOLD_CYC), 32'h1);
    chk(32'(cpu_clock_go_n), 32'h0);
    chk(32'(two_phase_active), 32'h0);
    @(posedge core_clk);
    supply_low_lockout <= 1'b1;
    repeat (10) @(negedge core_clk);
    chk(32'({output_sense_ref_discharge, cpu_clock_go_n}), 32'h3);
    @(posedge core_clk);
    supply_low_lockout <= 1'b0;
    $display("shutdown test done");
    stop_test();
  end
endmodule
`default_nettype wire
